//--- core/prefixed_opcode_decoder.sv
// decoder for the index, indexed-bit and extended prefixed opcode groups
`timescale 1ns/1ps
`default_nettype none
`include "prefixed_decoder_regs.svh"
module prefixed_opcode_decoder
   import prefixed_decoder_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // opcode and operand bytes from program memory
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   // current index register contents
   input wire logic [15:0] index_reg_first,
   input wire logic [15:0] index_reg_second,
   // decoded instruction
   output logic op_valid,
   output op_class_e op_class,
   output logic [7:0] op_byte,
   output logic op_index,
   output logic [2:0] op_sel,
   output logic [2:0] op_src,
   output logic [1:0] op_pair,
   output logic op_down,
   output logic op_repeat,
   output logic [1:0] op_mode,
   output logic [7:0] op_disp,
   output logic [7:0] op_imm8,
   output logic [15:0] op_imm16,
   output logic [15:0] op_eff_addr,
   output logic [15:0] op_restart_addr,
   output logic dec_busy
);
   function automatic decode_s pack_dec(input op_class_e c, input logic d,
                                        input logic n, input logic w);
      return decode_s'{c, d, n, w};
   endfunction : pack_dec
   // second byte after an index prefix
   function automatic decode_s dec_indexed(input logic [7:0] b);
      decode_s r;
      r = pack_dec(CLS_UNDEFINED, 1'b0, 1'b0, 1'b0);
      if (b[7:6] == `GRP_LOAD && b[2:0] == `FLD_MEM && b != `OP_HALT_SLOT)
         r = pack_dec(CLS_IDX_LOAD_REG, 1'b1, 1'b0, 1'b0);
      else if (b[7:3] == `OP_STORE_HI && b[2:0] != `FLD_MEM)
         r = pack_dec(CLS_IDX_STORE_REG, 1'b1, 1'b0, 1'b0);
      else if (b[7:6] == `GRP_ALU && b[2:0] == `FLD_MEM)
         r = pack_dec(CLS_IDX_ALU, 1'b1, 1'b0, 1'b0);
      else if (b[7:6] == `GRP_LOW && b[3:0] == `OP_ADD_LOW)
         r = pack_dec(CLS_IDX_ADD16, 1'b0, 1'b0, 1'b0);
      else
      begin
         case (b)
            `OP_INC_MEM: r = pack_dec(CLS_IDX_INC_MEM, 1'b1, 1'b0, 1'b0);
            `OP_DEC_MEM: r = pack_dec(CLS_IDX_DEC_MEM, 1'b1, 1'b0, 1'b0);
            `OP_STORE_IMM: r = pack_dec(CLS_IDX_STORE_IMM, 1'b1, 1'b1, 1'b0);
            `OP_LOAD_IMM16: r = pack_dec(CLS_IDX_LOAD_IMM16, 1'b0, 1'b0, 1'b1);
            `OP_STORE_DIRECT: r = pack_dec(CLS_IDX_STORE_DIRECT, 1'b0, 1'b0, 1'b1);
            `OP_LOAD_DIRECT: r = pack_dec(CLS_IDX_LOAD_DIRECT, 1'b0, 1'b0, 1'b1);
            `OP_INC_INDEX: r = pack_dec(CLS_IDX_INC_REG, 1'b0, 1'b0, 1'b0);
            `OP_DEC_INDEX: r = pack_dec(CLS_IDX_DEC_REG, 1'b0, 1'b0, 1'b0);
            `OP_POP: r = pack_dec(CLS_IDX_POP, 1'b0, 1'b0, 1'b0);
            `OP_EXCH_SP: r = pack_dec(CLS_IDX_EXCH_SP, 1'b0, 1'b0, 1'b0);
            `OP_PUSH: r = pack_dec(CLS_IDX_PUSH, 1'b0, 1'b0, 1'b0);
            `OP_JUMP: r = pack_dec(CLS_IDX_JUMP, 1'b0, 1'b0, 1'b0);
            `OP_LOAD_SP: r = pack_dec(CLS_IDX_LOAD_SP, 1'b0, 1'b0, 1'b0);
            default: r = pack_dec(CLS_UNDEFINED, 1'b0, 1'b0, 1'b0);
         endcase
      end
      return r;
   endfunction : dec_indexed
   // operation byte of the four-byte indexed bit group
   function automatic op_class_e dec_bitgroup(input logic [7:0] b);
      op_class_e c;
      c = CLS_UNDEFINED;
      if (b[2:0] == `FLD_MEM)
      begin
         case (b[7:6])
            `GRP_LOW: c = (b[5:3] == `FLD_MEM) ? CLS_UNDEFINED : CLS_IDX_ROTATE;
            `GRP_LOAD: c = CLS_IDX_BIT_TEST;
            `GRP_ALU: c = CLS_IDX_BIT_CLEAR;
            default: c = CLS_IDX_BIT_SET;
         endcase
      end
      return c;
   endfunction : dec_bitgroup
   // second byte after the extended prefix
   function automatic decode_s dec_extended(input logic [7:0] b);
      decode_s r;
      r = pack_dec(CLS_UNDEFINED, 1'b0, 1'b0, 1'b0);
      if (b[7:5] == `EX_BLOCK_TOP && !b[2])
      begin
         case (b[1:0])
            `BLK_MOVE: r.cls = CLS_BLOCK_MOVE;
            `BLK_CMP: r.cls = CLS_BLOCK_COMPARE;
            `BLK_IN: r.cls = CLS_BLOCK_IN;
            default: r.cls = CLS_BLOCK_OUT;
         endcase
      end
      else if (b[7:6] == `GRP_LOAD)
      begin
         case (b)
            `EX_NEGATE: r.cls = CLS_ACCUMULATOR_NEGATE;
            `EX_RET_NMI: r.cls = CLS_RETURN_FROM_NONMASKABLE;
            `EX_RET_INT: r.cls = CLS_RETURN_FROM_MASKABLE;
            `EX_MODE0, `EX_MODE1, `EX_MODE2:
               r.cls = CLS_INTERRUPT_RESPONSE_SELECT;
            `EX_VEC_FROM_ACC: r.cls = CLS_VECTOR_FROM_ACC;
            `EX_ACC_FROM_VEC: r.cls = CLS_ACC_FROM_VECTOR;
            `EX_DIGIT_RIGHT: r.cls = CLS_DIGIT_ROTATE_RIGHT;
            `EX_DIGIT_LEFT: r.cls = CLS_DIGIT_ROTATE_LEFT;
            default:
            begin
               // the memory slot (110) has no port form here, and pair 10 has no pair load or store form
               if (b[2:0] == `EX_PORT_IN && b[5:3] != `FLD_MEM)
                  r.cls = CLS_PORT_IN;
               else if (b[2:0] == `EX_PORT_OUT && b[5:3] != `FLD_MEM)
                  r.cls = CLS_PORT_OUT;
               else if (b[2:0] == `EX_ARITH16)
                  r.cls = b[3] ? CLS_ADD16_CARRY : CLS_SUB16_BORROW;
               else if (b[2:0] == `EX_PAIR_MEM && b[5:4] != `EX_PAIR_HL)
                  r = pack_dec(b[3] ? CLS_PAIR_LOAD : CLS_PAIR_STORE,
                               1'b0, 1'b0, 1'b1);
            end
         endcase
      end
      return r;
   endfunction : dec_extended
   dec_state_e state;
   op_class_e pend_class;
   logic pend_index;
   logic pend_imm8;
   logic [7:0] pend_byte;
   logic [7:0] disp_q;
   logic [7:0] word_lo_q;
   logic done;
   op_class_e fin_class;
   logic [7:0] fin_byte;
   logic fin_index;
   logic [7:0] fin_disp;
   logic [7:0] fin_imm8;
   logic [15:0] fin_word;
   dec_state_e next_state;
   decode_s ix_dec;
   decode_s ex_dec;
   assign ix_dec = dec_indexed(byte_data);
   assign ex_dec = dec_extended(byte_data);

   always_comb
   begin
      done = 1'b0;
      fin_class = pend_class;
      fin_byte = pend_byte;
      fin_index = pend_index;
      fin_disp = disp_q;
      fin_imm8 = '0;
      fin_word = '0;
      next_state = state;
      if (byte_valid)
      begin
         case (state)
            ST_OPCODE:
            begin
               fin_byte = byte_data;
               fin_index = 1'b0;
               if (byte_data == `PFX_INDEX_FIRST || byte_data == `PFX_INDEX_SECOND)
                  next_state = ST_INDEXED;
               else if (byte_data == `PFX_EXTENDED)
                  next_state = ST_EXTENDED;
               else
               begin
                  done = 1'b1;
                  fin_class = (byte_data[7:6] == `GRP_HIGH &&
                               byte_data[2:0] == `FLD_RESTART)
                              ? CLS_RESTART : CLS_BASE;
               end
            end
            ST_INDEXED:
            begin
               fin_byte = byte_data;
               fin_class = ix_dec.cls;
               if (byte_data == `PFX_BIT_GROUP)
                  next_state = ST_BIT_DISP;
               else if (ix_dec.need_disp)
                  next_state = ST_DISP;
               else if (ix_dec.need_word)
                  next_state = ST_WORD_LO;
               else
               begin
                  done = 1'b1;
                  next_state = ST_OPCODE;
               end
            end
            ST_EXTENDED:
            begin
               fin_byte = byte_data;
               fin_class = ex_dec.cls;
               if (ex_dec.need_word)
                  next_state = ST_WORD_LO;
               else
               begin
                  done = 1'b1;
                  next_state = ST_OPCODE;
               end
            end
            ST_DISP:
            begin
               fin_disp = byte_data;
               if (pend_imm8)
                  next_state = ST_IMM8;
               else
               begin
                  done = 1'b1;
                  next_state = ST_OPCODE;
               end
            end
            ST_IMM8:
            begin
               fin_imm8 = byte_data;
               done = 1'b1;
               next_state = ST_OPCODE;
            end
            ST_WORD_LO: next_state = ST_WORD_HI;
            ST_WORD_HI:
            begin
               fin_word = {byte_data, word_lo_q}; // low byte arrives first
               done = 1'b1;
               next_state = ST_OPCODE;
            end
            ST_BIT_DISP:
            begin
               fin_disp = byte_data;
               next_state = ST_BIT_OP;
            end
            ST_BIT_OP:
            begin
               fin_byte = byte_data;
               fin_class = dec_bitgroup(byte_data);
               done = 1'b1;
               next_state = ST_OPCODE;
            end
            default: next_state = ST_OPCODE;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         state <= ST_OPCODE;
      else
         state <= next_state;
   end
   // pending instruction held while its operand bytes arrive
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pend_class <= CLS_NONE;
         pend_index <= 1'b0;
         pend_imm8 <= 1'b0;
         pend_byte <= '0;
         disp_q <= '0;
         word_lo_q <= '0;
      end
      else if (byte_valid)
      begin
         if (state == ST_OPCODE)
            pend_index <= (byte_data == `PFX_INDEX_SECOND);
         if (state == ST_INDEXED)
         begin
            pend_class <= ix_dec.cls;
            pend_imm8 <= ix_dec.need_imm8;
            pend_byte <= byte_data;
         end
         if (state == ST_EXTENDED)
         begin
            pend_class <= ex_dec.cls;
            pend_imm8 <= 1'b0;
            pend_byte <= byte_data;
         end
         if (state == ST_DISP || state == ST_BIT_DISP)
            disp_q <= byte_data;
         if (state == ST_WORD_LO)
            word_lo_q <= byte_data;
      end
   end
   // decoded result, one-cycle strobe with fields held until the next one
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         op_valid <= 1'b0;
         op_class <= CLS_NONE;
         op_byte <= '0;
         op_index <= 1'b0;
         op_sel <= '0;
         op_src <= '0;
         op_pair <= '0;
         op_down <= 1'b0;
         op_repeat <= 1'b0;
         op_mode <= `MODE_ZERO;
         op_disp <= '0;
         op_imm8 <= '0;
         op_imm16 <= '0;
         op_eff_addr <= '0;
         op_restart_addr <= '0;
      end
      else
      begin
         op_valid <= done;
         if (done)
         begin
            op_class <= fin_class;
            op_byte <= fin_byte;
            op_index <= fin_index;
            op_sel <= fin_byte[5:3];
            op_src <= fin_byte[2:0];
            op_pair <= fin_byte[5:4];
            op_down <= fin_byte[3];
            op_repeat <= fin_byte[4];
            op_mode <= fin_byte[4] ? (fin_byte[3] ? `MODE_TWO : `MODE_ONE)
                                   : `MODE_ZERO;
            op_disp <= fin_disp;
            op_imm8 <= fin_imm8;
            op_imm16 <= fin_word;
            // sign-extended so that displacements 80..FF reach backwards
            op_eff_addr <= (fin_index ? index_reg_second : index_reg_first)
                           + {{8{fin_disp[7]}}, fin_disp};
            op_restart_addr <= {8'h00, 2'b00, fin_byte[5:3], `RESTART_PAD};
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         dec_busy <= 1'b0;
      else
         dec_busy <= (next_state != ST_OPCODE);
   end
endmodule : prefixed_opcode_decoder
`default_nettype wire

//--- pkg/prefixed_decoder_regs.svh
// opcode values and field positions for the prefixed opcode decoder
`ifndef PREFIXED_DECODER_REGS_SVH
`define PREFIXED_DECODER_REGS_SVH
`define PFX_INDEX_FIRST 8'hdd
`define PFX_INDEX_SECOND 8'hfd
`define PFX_EXTENDED 8'hed
`define PFX_BIT_GROUP 8'hcb
`define FLD_MEM 3'b110
`define FLD_RESTART 3'b111
`define GRP_LOAD 2'b01
`define GRP_ALU 2'b10
`define GRP_HIGH 2'b11
`define GRP_LOW 2'b00
`define OP_HALT_SLOT 8'h76
`define OP_STORE_HI 5'b0_1110
`define OP_INC_MEM 8'h34
`define OP_DEC_MEM 8'h35
`define OP_STORE_IMM 8'h36
`define OP_LOAD_IMM16 8'h21
`define OP_STORE_DIRECT 8'h22
`define OP_LOAD_DIRECT 8'h2a
`define OP_INC_INDEX 8'h23
`define OP_DEC_INDEX 8'h2b
`define OP_ADD_LOW 4'h9
`define OP_POP 8'he1
`define OP_EXCH_SP 8'he3
`define OP_PUSH 8'he5
`define OP_JUMP 8'he9
`define OP_LOAD_SP 8'hf9
`define EX_NEGATE 8'h44
`define EX_RET_NMI 8'h45
`define EX_RET_INT 8'h4d
`define EX_MODE0 8'h46
`define EX_MODE1 8'h56
`define EX_MODE2 8'h5e
`define EX_VEC_FROM_ACC 8'h47
`define EX_ACC_FROM_VEC 8'h57
`define EX_DIGIT_RIGHT 8'h67
`define EX_DIGIT_LEFT 8'h6f
`define EX_PORT_IN 3'b000
`define EX_PORT_OUT 3'b001
`define EX_ARITH16 3'b010
`define EX_PAIR_MEM 3'b011
`define EX_PAIR_HL 2'b10
`define EX_BLOCK_TOP 3'b101
`define BLK_MOVE 2'b00
`define BLK_CMP 2'b01
`define BLK_IN 2'b10
`define BLK_OUT 2'b11
`define MODE_ZERO 2'b00
`define MODE_ONE 2'b01
`define MODE_TWO 2'b10
`define RESTART_PAD 3'b000
`endif

//--- pkg/prefixed_decoder_pkg.sv
// types shared by the prefixed opcode decoder
package prefixed_decoder_pkg;
   typedef enum logic [5:0] {
      CLS_NONE, CLS_BASE, CLS_RESTART, CLS_UNDEFINED,
      CLS_IDX_LOAD_REG, CLS_IDX_STORE_REG, CLS_IDX_ALU, CLS_IDX_INC_MEM,
      CLS_IDX_DEC_MEM, CLS_IDX_STORE_IMM, CLS_IDX_ROTATE, CLS_IDX_BIT_TEST,
      CLS_IDX_BIT_CLEAR, CLS_IDX_BIT_SET, CLS_IDX_POP, CLS_IDX_EXCH_SP,
      CLS_IDX_PUSH, CLS_IDX_JUMP, CLS_IDX_LOAD_SP, CLS_IDX_LOAD_IMM16,
      CLS_IDX_STORE_DIRECT, CLS_IDX_LOAD_DIRECT, CLS_IDX_INC_REG,
      CLS_IDX_DEC_REG, CLS_IDX_ADD16, CLS_PORT_IN, CLS_PORT_OUT,
      CLS_SUB16_BORROW, CLS_ADD16_CARRY, CLS_ACCUMULATOR_NEGATE,
      CLS_INTERRUPT_RESPONSE_SELECT, CLS_RETURN_FROM_NONMASKABLE,
      CLS_RETURN_FROM_MASKABLE, CLS_VECTOR_FROM_ACC, CLS_ACC_FROM_VECTOR,
      CLS_DIGIT_ROTATE_RIGHT, CLS_DIGIT_ROTATE_LEFT, CLS_PAIR_STORE,
      CLS_PAIR_LOAD, CLS_BLOCK_MOVE, CLS_BLOCK_COMPARE, CLS_BLOCK_IN,
      CLS_BLOCK_OUT
   } op_class_e;

   typedef enum logic [8:0] {
      ST_OPCODE = 9'b0_0000_0001,
      ST_INDEXED = 9'b0_0000_0010,
      ST_EXTENDED = 9'b0_0000_0100,
      ST_DISP = 9'b0_0000_1000,
      ST_IMM8 = 9'b0_0001_0000,
      ST_WORD_LO = 9'b0_0010_0000,
      ST_WORD_HI = 9'b0_0100_0000,
      ST_BIT_DISP = 9'b0_1000_0000,
      ST_BIT_OP = 9'b1_0000_0000
   } dec_state_e;

   typedef struct packed {
      op_class_e cls;
      logic need_disp;
      logic need_imm8;
      logic need_word;
   } decode_s;
endpackage : prefixed_decoder_pkg

//--- verification/prefixed_decoder_assertions.sv
// concurrent checks on the prefixed opcode decoder ports
`timescale 1ns/1ps
`default_nettype none
module prefixed_decoder_checker
   import prefixed_decoder_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // byte stream and index values
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic [15:0] index_reg_first,
   input wire logic [15:0] index_reg_second,
   // decoded instruction
   input wire logic op_valid,
   input wire op_class_e op_class,
   input wire logic [7:0] op_byte,
   input wire logic op_index,
   input wire logic [2:0] op_sel,
   input wire logic [1:0] op_pair,
   input wire logic op_down,
   input wire logic op_repeat,
   input wire logic [1:0] op_mode,
   input wire logic [7:0] op_disp,
   input wire logic [15:0] op_eff_addr,
   input wire logic [15:0] op_restart_addr,
   input wire logic dec_busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // only fires when the prefix starts from idle, so operand bytes never match
   property p_two(logic [7:0] p, logic [7:0] b, op_class_e c);
      (byte_valid && byte_data == p && !dec_busy) ##1 (byte_valid && byte_data == b)
         |=> op_valid && op_class == c;
   endproperty
   a_negate_decode: assert property (p_two(8'hed, 8'h44, CLS_ACCUMULATOR_NEGATE))
      else $error("negate code not decoded in time");
   a_nmi_return: assert property (p_two(8'hed, 8'h45, CLS_RETURN_FROM_NONMASKABLE))
      else $error("nonmaskable return not decoded in time");
   a_index_jump: assert property (p_two(8'hdd, 8'he9, CLS_IDX_JUMP))
      else $error("index jump not decoded in time");
   a_undef_result: assert property (p_two(8'hfd, 8'h76, CLS_UNDEFINED))
      else $error("unlisted index code not reported as undefined");
   a_restart_target: assert property (op_valid && op_class == CLS_RESTART
      |-> op_restart_addr == {10'h000, op_byte[5:3], 3'b000})
      else $error("restart address wrong");
   a_mode_select: assert property (op_valid && op_class == CLS_INTERRUPT_RESPONSE_SELECT
      |-> op_mode == (op_byte == 8'h46 ? 2'd0 : op_byte == 8'h56 ? 2'd1 : 2'd2))
      else $error("response mode wrong");
   a_eff_addr_sum: assert property (op_valid && op_class == CLS_IDX_LOAD_REG
      |-> op_eff_addr == (op_index ? $past(index_reg_second) : $past(index_reg_first))
      + {{8{op_disp[7]}}, op_disp})
      else $error("effective address wrong");
   a_bit_set_field: assert property (op_valid && op_class == CLS_IDX_BIT_SET
      |-> op_byte[7:6] == 2'b11 && op_byte[2:0] == 3'b110 && op_sel == op_byte[5:3])
      else $error("bit set decode wrong");
   a_block_fields: assert property (op_valid && (op_class == CLS_BLOCK_MOVE
      || op_class == CLS_BLOCK_COMPARE) |-> op_byte[7:5] == 3'b101 && op_down == op_byte[3]
      && op_repeat == op_byte[4] && op_byte[0] == (op_class == CLS_BLOCK_COMPARE))
      else $error("block move or compare fields wrong");
   a_pair_field: assert property (op_valid && op_class == CLS_PAIR_LOAD
      |-> op_pair == op_byte[5:4] && op_byte[3:0] == 4'hb)
      else $error("pair load fields wrong");
   a_prefix_busy: assert property (byte_valid && byte_data == 8'hdd && !dec_busy
      |=> dec_busy)
      else $error("decoder not busy after index prefix");
   c_bit_set: cover property (op_valid && op_class == CLS_IDX_BIT_SET);
   c_block_move: cover property (op_valid && op_class == CLS_BLOCK_MOVE);
   c_undefined: cover property (op_valid && op_class == CLS_UNDEFINED);
endmodule : prefixed_decoder_checker
bind prefixed_opcode_decoder prefixed_decoder_checker i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
   .byte_valid(byte_valid), .byte_data(byte_data), .index_reg_first(index_reg_first),
   .index_reg_second(index_reg_second), .op_valid(op_valid), .op_class(op_class),
   .op_byte(op_byte), .op_index(op_index), .op_sel(op_sel), .op_pair(op_pair),
   .op_down(op_down), .op_repeat(op_repeat), .op_mode(op_mode), .op_disp(op_disp),
   .op_eff_addr(op_eff_addr), .op_restart_addr(op_restart_addr), .dec_busy(dec_busy));
`default_nettype wire

//--- verification/prog_mem.sv
// program memory model feeding instruction bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module prog_mem
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // byte stream
   output logic byte_valid,
   output logic [7:0] byte_data
);
   logic [7:0] pending[$];
   int gap = 0;
   int idle = 0;
   task automatic put(input logic [7:0] b);
      pending.push_back(b);
   endtask : put
   // idle cycles invert byte_data every cycle, so stale data alternates with its inverse
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
         idle = 0;
      end
      else if (idle == 0 && pending.size() > 0)
      begin
         byte_valid <= 1'b1;
         byte_data <= pending.pop_front();
         idle = gap;
      end
      else
      begin
         byte_valid <= 1'b0;
         byte_data <= ~byte_data;
         if (idle > 0)
            idle = idle - 1;
      end
   end
endmodule : prog_mem
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the prefixed opcode decoder
`timescale 1ns/1ps
`default_nettype none
module tb
   import prefixed_decoder_pkg::*;
();
   logic clk_sys, rst_b, byte_valid, op_valid, op_index, op_down, op_repeat, dec_busy;
   logic [7:0] byte_data, op_byte, op_disp, op_imm8;
   logic [15:0] index_reg_first, index_reg_second, op_imm16, op_eff_addr, op_restart_addr;
   logic [2:0] op_sel, op_src;
   logic [1:0] op_pair, op_mode;
   op_class_e op_class;
   int fail_count = 0;
   int compares = 0;
   prog_mem i_mem (.clk_sys(clk_sys), .rst_b(rst_b), .byte_valid(byte_valid),
      .byte_data(byte_data));
   prefixed_opcode_decoder i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .byte_valid(byte_valid),
      .byte_data(byte_data), .index_reg_first(index_reg_first),
      .index_reg_second(index_reg_second), .op_valid(op_valid), .op_class(op_class),
      .op_byte(op_byte), .op_index(op_index), .op_sel(op_sel), .op_src(op_src),
      .op_pair(op_pair), .op_down(op_down), .op_repeat(op_repeat), .op_mode(op_mode),
      .op_disp(op_disp), .op_imm8(op_imm8), .op_imm16(op_imm16), .op_eff_addr(op_eff_addr),
      .op_restart_addr(op_restart_addr), .dec_busy(dec_busy));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cls(input op_class_e e);
      chk("class", 16'(op_class), 16'(e));
   endtask : cls
   // fields are read on the edge that closes the op_valid cycle
   task automatic run(input logic [7:0] b[$]);
      int n;
      n = 0;
      foreach (b[i])
         i_mem.put(b[i]);
      @(posedge clk_sys);
      while (op_valid !== 1'b1 && n < 60)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk("valid", 16'(op_valid), 16'h0001);
      chk("busy", 16'(dec_busy), 16'h0000);
   endtask : run
   task automatic t_index;
      op_class_e c[5] = '{CLS_IDX_POP, CLS_IDX_EXCH_SP, CLS_IDX_PUSH, CLS_IDX_JUMP,
         CLS_IDX_LOAD_SP};
      logic [7:0] b[5] = '{8'he1, 8'he3, 8'he5, 8'he9, 8'hf9};
      index_reg_first <= 16'h1000;
      index_reg_second <= 16'h2000;
      run('{8'hdd, 8'h66, 8'h05});
      cls(CLS_IDX_LOAD_REG);
      chk("sel", 16'(op_sel), 16'h0004);
      chk("eff", op_eff_addr, 16'h1005);
      chk("disp", 16'(op_disp), 16'h0005);
      chk("byte", 16'(op_byte), 16'h0066);
      run('{8'hfd, 8'h46, 8'hf0});
      chk("index", 16'(op_index), 16'h0001);
      chk("eff", op_eff_addr, 16'h1ff0);
      for (int i = 0; i < 10; i++)
      begin
         run('{i[0] ? 8'hfd : 8'hdd, b[i / 2]});
         cls(c[i / 2]);
         chk("index", 16'(op_index), 16'(i[0]));
      end
      run('{8'hfd, 8'h76});
      cls(CLS_UNDEFINED);
      run('{8'hed, 8'h4e});
      cls(CLS_UNDEFINED);
      run('{8'hfd, 8'h77, 8'h03});
      cls(CLS_IDX_STORE_REG);
      chk("src", 16'(op_src), 16'h0007);
      chk("index", 16'(op_index), 16'h0001);
      chk("eff", op_eff_addr, 16'h2003);
      run('{8'hfd, 8'h23});
      cls(CLS_IDX_INC_REG);
      run('{8'hfd, 8'h2b});
      cls(CLS_IDX_DEC_REG);
      run('{8'hfd, 8'h09});
      cls(CLS_IDX_ADD16);
      run('{8'hdd, 8'h86, 8'h01});
      cls(CLS_IDX_ALU);
      run('{8'hdd, 8'h34, 8'h02});
      cls(CLS_IDX_INC_MEM);
      run('{8'hdd, 8'h35, 8'h03});
      cls(CLS_IDX_DEC_MEM);
      chk("byte", 16'(op_byte), 16'h0035);
      chk("disp", 16'(op_disp), 16'h0003);
      $display("done t_index");
   endtask : t_index
   task automatic t_bit_group;
      op_class_e e;
      i_mem.gap = 2;
      for (int g = 0; g < 4; g++)
         for (int k = 0; k < 8; k++)
         begin
            e = g == 1 ? CLS_IDX_BIT_TEST : g == 2 ? CLS_IDX_BIT_CLEAR : CLS_IDX_BIT_SET;
            if (g == 0)
               e = k == 6 ? CLS_UNDEFINED : CLS_IDX_ROTATE;
            run('{8'hdd, 8'hcb, 8'h80, {2'(g), 3'(k), 3'b110}});
            cls(e);
            chk("sel", 16'(op_sel), 16'(k));
            chk("eff", op_eff_addr, 16'h0f80);
         end
      i_mem.gap = 0;
      $display("done t_bit_group");
   endtask : t_bit_group
   task automatic t_extended;
      logic [7:0] b[7] = '{8'h44, 8'h45, 8'h4d, 8'h47, 8'h57, 8'h67, 8'h6f};
      op_class_e c[7] = '{CLS_ACCUMULATOR_NEGATE, CLS_RETURN_FROM_NONMASKABLE,
         CLS_RETURN_FROM_MASKABLE, CLS_VECTOR_FROM_ACC, CLS_ACC_FROM_VECTOR,
         CLS_DIGIT_ROTATE_RIGHT, CLS_DIGIT_ROTATE_LEFT};
      op_class_e k[4] = '{CLS_BLOCK_MOVE, CLS_BLOCK_COMPARE, CLS_BLOCK_IN, CLS_BLOCK_OUT};
      foreach (b[i])
      begin
         run('{8'hed, b[i]});
         cls(c[i]);
      end
      for (int m = 0; m < 3; m++)
      begin
         run('{8'hed, m == 0 ? 8'h46 : m == 1 ? 8'h56 : 8'h5e});
         chk("mode", 16'(op_mode), 16'(m));
      end
      for (int j = 0; j < 16; j++)
      begin
         run('{8'hed, {3'b101, 2'(j / 4), 1'b0, 2'(j)}});
         cls(k[j % 4]);
         chk("updown", 16'({op_repeat, op_down}), 16'(j / 4));
      end
      for (int r = 0; r < 16; r++)
         if (r / 2 != 6)
         begin
            run('{8'hed, {2'b01, 3'(r / 2), 2'b00, r[0]}});
            cls(r[0] ? CLS_PORT_OUT : CLS_PORT_IN);
            chk("sel", 16'(op_sel), 16'(r / 2));
            run('{8'hed, {2'b01, 2'(r / 2), r[0], 3'b010}});
            cls(r[0] ? CLS_ADD16_CARRY : CLS_SUB16_BORROW);
            chk("pair", 16'(op_pair), 16'(r / 2 % 4));
         end
      $display("done t_extended");
   endtask : t_extended
   task automatic t_operands;
      run('{8'hfd, 8'h21, 8'h34, 8'h12});
      cls(CLS_IDX_LOAD_IMM16);
      chk("imm16", op_imm16, 16'h1234);
      run('{8'hfd, 8'h22, 8'h78, 8'h56});
      cls(CLS_IDX_STORE_DIRECT);
      chk("imm16", op_imm16, 16'h5678);
      run('{8'hfd, 8'h2a, 8'hcd, 8'hab});
      cls(CLS_IDX_LOAD_DIRECT);
      chk("imm16", op_imm16, 16'habcd);
      run('{8'hed, 8'h4b, 8'h34, 8'h12});
      cls(CLS_PAIR_LOAD);
      chk("imm16", op_imm16, 16'h1234);
      chk("pair", 16'(op_pair), 16'h0000);
      run('{8'hed, 8'h73, 8'hcd, 8'hab});
      cls(CLS_PAIR_STORE);
      chk("pair", 16'(op_pair), 16'h0003);
      run('{8'hfd, 8'h36, 8'h80, 8'h5a});
      cls(CLS_IDX_STORE_IMM);
      chk("imm8", 16'(op_imm8), 16'h005a);
      chk("eff", op_eff_addr, 16'h1f80);
      for (int k = 3; k < 8; k++)
      begin
         run('{{2'b11, 3'(k), 3'b111}});
         cls(CLS_RESTART);
         chk("restart", op_restart_addr, 16'(k * 8));
      end
      run('{8'he9});
      cls(CLS_BASE);
      $display("done t_operands");
   endtask : t_operands
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial
   begin
      rst_b = 1'b0;
      index_reg_first = 16'h0000;
      index_reg_second = 16'h0000;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      t_index();
      t_bit_group();
      t_extended();
      t_operands();
      end_of_test();
   end
   // the whole run needs under a thousand cycles
   initial
   begin
      #(50 * 20000);
      fail_count++;
      end_of_test();
   end
endmodule : tb
`default_nettype wire
